// ---- rtl/spx_pkg.sv ----
// Constants and types shared by the simplex, checksum and error logic.
package spx_pkg;
    localparam int CFG_W = 8;
    localparam int CF_SWM = 0;
    localparam int CF_RXO = 1;
    localparam int CF_SSM = 2;
    localparam int CF_SSI = 3;
    localparam int CF_CLOCK_PHASE = 4;
    localparam int CF_CLOCK_POLARITY = 5;
    localparam int CF_F16 = 6;
    localparam int CF_CK = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam int LK_W = 14;
    localparam int LK_EN = 8;
    localparam int LK_MS = 9;
    localparam int LK_NXT = 10;
    localparam int LK_DRV = 11;
    localparam int LK_TREQ = 12;
    localparam int LK_CLR = 13;
    localparam logic [4:0] LEN8 = 5'h08;
    localparam logic [4:0] LEN16 = 5'h10;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    typedef enum logic [1:0] {
        SPX_IDLE = 2'b01,
        SPX_RUN  = 2'b10
    } spx_lstate_e;
endpackage : spx_pkg

// ---- rtl/spx_crc.sv ----
// Serial checksum register, one bit per step, 8 or 16 bits wide.
`timescale 1ns/10ps
module spx_crc import spx_pkg::*; (
    input  wire logic        clk_link,
    input  wire logic        arst_n,
    input  wire logic        clr,
    input  wire logic        step,
    input  wire logic        bit_in,
    input  wire logic        wide,
    input  wire logic [15:0] poly,
    output logic      [15:0] crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic        fb;

    always_comb begin
        fb = bit_in ^ (wide ? crc_reg[15] : crc_reg[7]);
        crc_next = crc_reg;
        if (clr) begin
            crc_next = CRC_INIT;
        end else if (step) begin
            crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
            if (!wide) begin
                crc_next[15:8] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            crc_reg <= CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule : spx_crc

// ---- rtl/spx_ctrl.sv ----
// Serial peripheral controller: simplex modes, status, checksum, DMA and error flags.
`timescale 1ns/10ps
module spx_ctrl import spx_pkg::*; (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             clk_link,
    input  wire logic             ctl_a_wr,
    input  wire logic             cfg_enable,
    input  wire logic             cfg_master,
    input  wire logic [CFG_W-1:0] cfg_bits,
    input  wire logic             cfg_send_checksum_next,
    input  wire logic             single_wire_drive_out,
    input  wire logic             error_irq_enable,
    input  wire logic             tx_irq_enable,
    input  wire logic             rx_irq_enable,
    input  wire logic             tx_dma_enable,
    input  wire logic             rx_dma_enable,
    input  wire logic [15:0]      checksum_polynomial,
    input  wire logic             data_wr,
    input  wire logic [15:0]      data_wdata,
    input  wire logic             data_rd,
    input  wire logic             status_access,
    input  wire logic             status_rd,
    input  wire logic             status_crc_clr,
    input  wire logic             tx_dma_ack,
    input  wire logic             tx_dma_last,
    input  wire logic             rx_dma_ack,
    input  wire logic             sck_i,
    input  wire logic             mosi_i,
    input  wire logic             miso_i,
    input  wire logic             slave_select_n,
    output logic                  periph_enable,
    output logic                  master_select,
    output logic [CFG_W-1:0]      cfg_state,
    output logic                  send_checksum_next,
    output logic [15:0]           data_rdata,
    output logic                  busy_flag,
    output logic                  tx_buffer_empty,
    output logic                  rx_buffer_full,
    output logic                  mode_fault_flag,
    output logic                  overrun_flag,
    output logic                  checksum_mismatch_flag,
    output logic [15:0]           tx_checksum_value,
    output logic [15:0]           rx_checksum_value,
    output logic                  tx_dma_req,
    output logic                  rx_dma_req,
    output logic                  irq,
    output logic                  sck_o,
    output logic                  sck_oe,
    output logic                  mosi_o,
    output logic                  mosi_oe,
    output logic                  miso_o,
    output logic                  miso_oe
);
    // System-domain state.
    logic             ss_s1_reg, ss_s2_reg;
    logic [2:0]       ls1_reg, ls2_reg;
    logic             evd_reg, evd_next;
    logic             en_reg, en_next, ms_reg, ms_next;
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic             nxt_reg, nxt_next, clrt_reg, clrt_next;
    logic             mode_fault_flag_reg, mode_fault_flag_next, mfarm_reg, mfarm_next;
    logic             ovr_reg, ovr_next, ovarm_reg, ovarm_next;
    logic             cerr_reg, cerr_next, rxf_reg, rxf_next;
    logic [15:0]      rxd_reg, rxd_next, txb_reg, txb_next;
    logic             treq_reg, treq_next;
    logic             busy_reg, busy_next, txe_reg, txe_next;
    logic             txdr_reg, txdr_next, rxdr_reg, rxdr_next, irq_reg, irq_next;
    logic [15:0]      txcv_reg, txcv_next, rxcv_reg, rxcv_next;
    logic             sel_low, ev, wr, rd, pend, pend_next;
    // Link-domain state.
    logic [LK_W-1:0]  lk_s1_reg, lk_s2_reg, lk_vec;
    logic [3:0]       ps1_reg, ps2_reg;
    spx_lstate_e      st_reg, st_next;
    logic [15:0]      shf_reg, shf_next, ew_reg, ew_next;
    logic [15:0]      etc_reg, etc_next, erc_reg, erc_next;
    logic [4:0]       cnt_reg, cnt_next, len;
    logic             out_reg, out_next, sck_reg, sck_next, sckd_reg, clrd_reg;
    logic             crcf_reg, crcf_next, sent_reg, sent_next, ack_reg, ack_next;
    logic             evt_reg, evt_next, emis_reg, emis_next, act_reg, act_next;
    logic             soe_reg, soe_next, moe_reg, moe_next, soe2_reg, soe2_next;
    logic             ms, wide, clock_polarity, clock_phase, sel, lpend, crcsend, contin, go;
    logic             chg, lead, trail, samp, shev, din, drive, crc_clr, crc_step;
    logic [15:0]      tx_crc, rx_crc, shf_word;

    // Pin and link-event synchronisers into the system clock.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ss_s1_reg <= 1'b1;
            ss_s2_reg <= 1'b1;
            ls1_reg   <= 3'h0;
            ls2_reg   <= 3'h0;
        end else begin
            ss_s1_reg <= slave_select_n;
            ss_s2_reg <= ss_s1_reg;
            ls1_reg   <= {act_reg, ack_reg, evt_reg};
            ls2_reg   <= ls1_reg;
        end
    end

    always_comb begin
        sel_low = cfg_reg[CF_SSM] ? ~cfg_reg[CF_SSI] : ~ss_s2_reg;
        ev = ls2_reg[0] ^ evd_reg;
        evd_next = ls2_reg[0];
        wr = data_wr | tx_dma_ack;
        rd = data_rd | rx_dma_ack;
        pend = treq_reg ^ ls2_reg[1];
        en_next = en_reg;
        ms_next = ms_reg;
        cfg_next = cfg_reg;
        nxt_next = nxt_reg;
        clrt_next = clrt_reg;
        mode_fault_flag_next = mode_fault_flag_reg;
        mfarm_next = mfarm_reg;
        ovr_next = ovr_reg;
        ovarm_next = ovarm_reg;
        cerr_next = cerr_reg;
        rxf_next = rxf_reg;
        rxd_next = rxd_reg;
        txb_next = txb_reg;
        treq_next = treq_reg;
        txcv_next = txcv_reg;
        rxcv_next = rxcv_reg;
        if (ctl_a_wr) begin
            cfg_next = cfg_bits;
            nxt_next = cfg_send_checksum_next;
            en_next = cfg_enable & (en_reg | ~mode_fault_flag_reg);
            ms_next = cfg_master & (ms_reg | ~mode_fault_flag_reg);
            if (cfg_bits[CF_CK] && !cfg_reg[CF_CK]) begin
                clrt_next = ~clrt_reg;
            end
            if (mfarm_reg) begin
                mode_fault_flag_next = 1'b0;
                mfarm_next = 1'b0;
            end
        end
        if (status_access && mode_fault_flag_reg) begin
            mfarm_next = 1'b1;
        end
        if (ms_reg && sel_low) begin
            mode_fault_flag_next = 1'b1;
            en_next = 1'b0;
            ms_next = 1'b0;
        end
        if (status_rd && ovarm_reg) begin
            ovr_next = 1'b0;
            ovarm_next = 1'b0;
        end
        if (rd) begin
            rxf_next = 1'b0;
            ovarm_next = 1'b1;
        end
        if (status_crc_clr) begin
            cerr_next = 1'b0;
        end
        if (tx_dma_ack && tx_dma_last && cfg_reg[CF_CK]) begin
            nxt_next = 1'b1;
        end
        if (wr && !pend && en_reg) begin
            txb_next = data_wdata;
            treq_next = ~treq_reg;
        end
        // Frame events win over the overrun and checksum-error clears in the same cycle; a read still clears the receive flag.
        if (ev) begin
            txcv_next = etc_reg;
            rxcv_next = erc_reg;
            if (crcf_reg) begin
                nxt_next = 1'b0;
                cerr_next = cerr_reg | emis_reg;
            end else if (rxf_reg) begin
                ovr_next = 1'b1;
            end else begin
                rxf_next = 1'b1;
                rxd_next = ew_reg;
            end
        end
        pend_next = treq_next ^ ls2_reg[1];
        txe_next = en_next & ~pend_next;
        busy_next = en_next & (ls2_reg[2] | (ms_next & pend_next));
        txdr_next = en_next & tx_dma_enable & txe_next & ~wr;
        rxdr_next = en_next & rx_dma_enable & rxf_next & ~rd;
        irq_next = (error_irq_enable & (mode_fault_flag_next | ovr_next | cerr_next))
                 | (tx_irq_enable & txe_next) | (rx_irq_enable & rxf_next);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evd_reg <= 1'b0;
            en_reg <= 1'b0;
            ms_reg <= 1'b0;
            cfg_reg <= CFG_RST;
            nxt_reg <= 1'b0;
            clrt_reg <= 1'b0;
            mode_fault_flag_reg <= 1'b0;
            mfarm_reg <= 1'b0;
            ovr_reg <= 1'b0;
            ovarm_reg <= 1'b0;
            cerr_reg <= 1'b0;
            rxf_reg <= 1'b0;
            rxd_reg <= WORD_RST;
            txb_reg <= WORD_RST;
            treq_reg <= 1'b0;
            txcv_reg <= CRC_INIT;
            rxcv_reg <= CRC_INIT;
            busy_reg <= 1'b0;
            txe_reg <= 1'b0;
            txdr_reg <= 1'b0;
            rxdr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            evd_reg <= evd_next;
            en_reg <= en_next;
            ms_reg <= ms_next;
            cfg_reg <= cfg_next;
            nxt_reg <= nxt_next;
            clrt_reg <= clrt_next;
            mode_fault_flag_reg <= mode_fault_flag_next;
            mfarm_reg <= mfarm_next;
            ovr_reg <= ovr_next;
            ovarm_reg <= ovarm_next;
            cerr_reg <= cerr_next;
            rxf_reg <= rxf_next;
            rxd_reg <= rxd_next;
            txb_reg <= txb_next;
            treq_reg <= treq_next;
            txcv_reg <= txcv_next;
            rxcv_reg <= rxcv_next;
            busy_reg <= busy_next;
            txe_reg <= txe_next;
            txdr_reg <= txdr_next;
            rxdr_reg <= rxdr_next;
            irq_reg <= irq_next;
        end
    end

    // Configuration is quasi-static, so per-bit synchronisers are enough; it must
    // not change during a frame.
    assign lk_vec = {clrt_reg, treq_reg, single_wire_drive_out, nxt_reg, ms_reg, en_reg,
                     cfg_reg};

    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            lk_s1_reg <= {LK_W{1'b0}};
            lk_s2_reg <= {LK_W{1'b0}};
            ps1_reg <= 4'hf;
            ps2_reg <= 4'hf;
            sckd_reg <= 1'b1;
            clrd_reg <= 1'b0;
        end else begin
            lk_s1_reg <= lk_vec;
            lk_s2_reg <= lk_s1_reg;
            ps1_reg <= {slave_select_n, miso_i, mosi_i, sck_i};
            ps2_reg <= ps1_reg;
            sckd_reg <= ps2_reg[0];
            clrd_reg <= lk_s2_reg[LK_CLR];
        end
    end

    always_comb begin
        ms = lk_s2_reg[LK_MS];
        wide = lk_s2_reg[CF_F16];
        clock_polarity = lk_s2_reg[CF_CLOCK_POLARITY];
        clock_phase = lk_s2_reg[CF_CLOCK_PHASE];
        len = wide ? LEN16 : LEN8;
        sel = lk_s2_reg[CF_SSM] ? ~lk_s2_reg[CF_SSI] : ~ps2_reg[3];
        lpend = lk_s2_reg[LK_TREQ] ^ ack_reg;
        crcsend = lk_s2_reg[LK_NXT] & ~sent_reg & ~lpend;
        contin = lk_s2_reg[CF_RXO] | (lk_s2_reg[CF_SWM] & ~lk_s2_reg[LK_DRV]);
        go = lk_s2_reg[LK_EN] & (ms ? (lpend | crcsend | contin) : sel);
        chg = ps2_reg[0] ^ sckd_reg;
        if (ms) begin
            lead = (st_reg == SPX_RUN) & (sck_reg == clock_polarity);
            trail = (st_reg == SPX_RUN) & (sck_reg != clock_polarity);
        end else begin
            lead = (st_reg == SPX_RUN) & chg & (ps2_reg[0] != clock_polarity);
            trail = (st_reg == SPX_RUN) & chg & (ps2_reg[0] == clock_polarity);
        end
        samp = clock_phase ? trail : lead;
        shev = clock_phase ? lead : trail;
        // A master's returning data is timed by the clock it launches itself, so it is
        // taken from the pin at the sampling edge; the two-flop path would lag a whole
        // bit at this clock rate. A slave reads the synchronised copy.
        if (lk_s2_reg[CF_SWM]) begin
            din = ms ? mosi_i : ps2_reg[2];
        end else begin
            din = ms ? miso_i : ps2_reg[1];
        end
        crc_clr = lk_s2_reg[LK_CLR] ^ clrd_reg;
        crc_step = samp & ~crcf_reg & lk_s2_reg[CF_CK];
        st_next = st_reg;
        shf_next = shf_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        sck_next = clock_polarity;
        crcf_next = crcf_reg;
        sent_next = sent_reg & lk_s2_reg[LK_NXT];
        ack_next = ack_reg;
        evt_next = evt_reg;
        ew_next = ew_reg;
        emis_next = emis_reg;
        etc_next = etc_reg;
        erc_next = erc_reg;
        unique case (st_reg)
            SPX_IDLE: begin
                if (go) begin
                    st_next = SPX_RUN;
                    cnt_next = 5'h00;
                    crcf_next = 1'b0;
                    if (lpend) begin
                        shf_next = txb_reg;
                        ack_next = ~ack_reg;
                    end else if (crcsend) begin
                        shf_next = tx_crc;
                        crcf_next = 1'b1;
                    end else begin
                        shf_next = WORD_RST;
                    end
                    out_next = wide ? shf_next[15] : shf_next[7];
                end
            end
            SPX_RUN: begin
                sck_next = ms ? ~sck_reg : clock_polarity;
                if (samp) begin
                    shf_next = {shf_reg[14:0], din};
                    cnt_next = cnt_reg + 5'h01;
                end
                if (shev) begin
                    out_next = wide ? shf_reg[15] : shf_reg[7];
                end
                shf_word = wide ? shf_next : {8'h00, shf_next[7:0]};
                // The frame ends on its last trailing edge, so a master that was
                // disabled mid-frame still completes it.
                if (trail && cnt_next == len) begin
                    st_next = SPX_IDLE;
                    sck_next = clock_polarity;
                    evt_next = ~evt_reg;
                    ew_next = shf_word;
                    emis_next = crcf_reg & (shf_word != rx_crc);
                    etc_next = tx_crc;
                    erc_next = rx_crc;
                    sent_next = sent_reg | crcf_reg;
                end else if (!ms && !sel) begin
                    st_next = SPX_IDLE;
                end
            end
        endcase
        if (st_reg != SPX_RUN) begin
            shf_word = WORD_RST;
        end
        drive = lk_s2_reg[LK_EN] & ~lk_s2_reg[CF_RXO]
              & (~lk_s2_reg[CF_SWM] | lk_s2_reg[LK_DRV]);
        moe_next = ms & drive;
        soe_next = ~ms & drive & sel;
        soe2_next = ms & lk_s2_reg[LK_EN];
        act_next = (st_next == SPX_RUN);
    end

    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= SPX_IDLE;
            shf_reg <= WORD_RST;
            cnt_reg <= 5'h00;
            out_reg <= 1'b0;
            sck_reg <= 1'b0;
            crcf_reg <= 1'b0;
            sent_reg <= 1'b0;
            ack_reg <= 1'b0;
            evt_reg <= 1'b0;
            ew_reg <= WORD_RST;
            emis_reg <= 1'b0;
            etc_reg <= CRC_INIT;
            erc_reg <= CRC_INIT;
            moe_reg <= 1'b0;
            soe_reg <= 1'b0;
            soe2_reg <= 1'b0;
            act_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            shf_reg <= shf_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            sck_reg <= sck_next;
            crcf_reg <= crcf_next;
            sent_reg <= sent_next;
            ack_reg <= ack_next;
            evt_reg <= evt_next;
            ew_reg <= ew_next;
            emis_reg <= emis_next;
            etc_reg <= etc_next;
            erc_reg <= erc_next;
            moe_reg <= moe_next;
            soe_reg <= soe_next;
            soe2_reg <= soe2_next;
            act_reg <= act_next;
        end
    end

    spx_crc u_tx_crc (
        .clk_link (clk_link),
        .arst_n   (arst_n),
        .clr      (crc_clr),
        .step     (crc_step),
        .bit_in   (out_reg),
        .wide     (wide),
        .poly     (checksum_polynomial),
        .crc      (tx_crc)
    );

    spx_crc u_rx_crc (
        .clk_link (clk_link),
        .arst_n   (arst_n),
        .clr      (crc_clr),
        .step     (crc_step),
        .bit_in   (din),
        .wide     (wide),
        .poly     (checksum_polynomial),
        .crc      (rx_crc)
    );

    assign periph_enable = en_reg;
    assign master_select = ms_reg;
    assign cfg_state = cfg_reg;
    assign send_checksum_next = nxt_reg;
    assign data_rdata = rxd_reg;
    assign busy_flag = busy_reg;
    assign tx_buffer_empty = txe_reg;
    assign rx_buffer_full = rxf_reg;
    assign mode_fault_flag = mode_fault_flag_reg;
    assign overrun_flag = ovr_reg;
    assign checksum_mismatch_flag = cerr_reg;
    assign tx_checksum_value = txcv_reg;
    assign rx_checksum_value = rxcv_reg;
    assign tx_dma_req = txdr_reg;
    assign rx_dma_req = rxdr_reg;
    assign irq = irq_reg;
    assign sck_o = sck_reg;
    assign sck_oe = soe2_reg;
    assign mosi_o = out_reg;
    assign mosi_oe = moe_reg;
    assign miso_o = out_reg;
    assign miso_oe = soe_reg;
endmodule : spx_ctrl

// ---- tb/spx_asserts.sv ----
// Checker for error flags, buffer flags, interrupt and receive-only pin drivers.
`timescale 1ns/10ps
module spx_asserts import spx_pkg::*; (
    input wire logic             clk_sys,
    input wire logic             clk_link,
    input wire logic             arst_n,
    input wire logic             ctl_a_wr,
    input wire logic             data_rd,
    input wire logic             rx_dma_ack,
    input wire logic             status_rd,
    input wire logic             error_irq_enable,
    input wire logic             periph_enable,
    input wire logic             master_select,
    input wire logic [CFG_W-1:0] cfg_state,
    input wire logic             tx_buffer_empty,
    input wire logic             rx_buffer_full,
    input wire logic             mode_fault_flag,
    input wire logic             overrun_flag,
    input wire logic             irq,
    input wire logic             mosi_oe,
    input wire logic             miso_oe
);
    sequence off_twice;
        !periph_enable ##1 !periph_enable;
    endsequence
    sequence fault_pending;
        error_irq_enable ##1 mode_fault_flag;
    endsequence
    fault_demotes_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(mode_fault_flag) |-> !periph_enable && !master_select && $past(master_select))
        else $error("fault did not demote the master");
    fault_lock_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        mode_fault_flag && $past(mode_fault_flag) |-> !$rose(periph_enable) && !$rose(master_select))
        else $error("enable or master set during fault");
    fault_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(mode_fault_flag) |-> $past(ctl_a_wr)) else $error("fault cleared without control write");
    ovr_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(overrun_flag) |-> $past(status_rd)) else $error("overrun cleared without status read");
    rx_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(rx_buffer_full) |-> $past(data_rd || rx_dma_ack))
        else $error("receive flag cleared without read");
    txe_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        off_twice |-> !tx_buffer_empty) else $error("transmit empty set while disabled");
    irq_error_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        fault_pending |-> irq) else $error("enabled fault raised no interrupt");
    rxo_quiet_a: assert property (@(posedge clk_link) disable iff (!arst_n)
        cfg_state[CF_RXO] [*8] |-> !mosi_oe && !miso_oe) else $error("data driver on in receive-only");
endmodule : spx_asserts

bind spx_ctrl spx_asserts spx_asserts_inst (.*);

// ---- tb/spx_remote.sv ----
// Remote slave that answers each master frame with an alternating byte.
`timescale 1ns/10ps
module spx_remote (
    input  wire logic sck,
    input  wire logic arst_n,
    output logic      miso
);
    logic [7:0] reply_reg;
    logic [2:0] idx_reg;
    // Bits change on the trailing edge so the master samples a settled level on the leading one.
    always @(negedge sck or negedge arst_n) begin
        if (!arst_n) begin
            reply_reg <= 8'h3c;
            idx_reg <= 3'h0;
        end else begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == 3'h7) reply_reg <= ~reply_reg;
        end
    end
    assign miso = reply_reg[3'h7 - idx_reg];
endmodule : spx_remote

// ---- tb/spx_ctrl_test.sv ----
// Directed test of simplex, checksum and error flag behaviour.
`timescale 1ns/10ps
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, v); end end
module spx_ctrl_test import spx_pkg::*; ;
    logic clk_sys = 0, clk_link = 0, arst_n = 1, remote_miso, sck_i, mosi_i, miso_i;
    logic ctl_a_wr, cfg_enable, cfg_master, cfg_send_checksum_next, single_wire_drive_out;
    logic error_irq_enable, tx_irq_enable, rx_irq_enable, tx_dma_enable, rx_dma_enable;
    logic data_wr, data_rd, status_access, status_rd, status_crc_clr, tx_dma_ack;
    logic tx_dma_last, rx_dma_ack, slave_select_n, send_checksum_next, busy_flag;
    logic [7:0] cfg_bits, cfg_state;
    logic [15:0] checksum_polynomial, data_wdata, data_rdata, tx_checksum_value, rx_checksum_value;
    logic periph_enable, master_select, tx_buffer_empty, rx_buffer_full, mode_fault_flag;
    logic overrun_flag, checksum_mismatch_flag, tx_dma_req, rx_dma_req, irq;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    int errors = 0, check_count = 0, cyc = 0;
    // Released clock is pulled down; an undriven MOSI line shows the inverse of mosi_o, an undriven MISO line the remote slave.
    assign sck_i = sck_oe & sck_o;
    assign mosi_i = mosi_oe ? mosi_o : ~mosi_o;
    assign miso_i = miso_oe ? miso_o : remote_miso;
    spx_ctrl spx_ctrl_inst (.*);
    spx_remote spx_remote_inst (.sck(sck_i), .arst_n(arst_n), .miso(remote_miso));
    always #2 clk_sys = ~clk_sys;
    initial begin
        #13;
        forever #40 clk_link = ~clk_link;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    task automatic ctl(input logic en, ms, nx, input logic [7:0] b);
        {cfg_enable, cfg_master, cfg_send_checksum_next, cfg_bits} = {en, ms, nx, b};
        pulse(ctl_a_wr);
    endtask : ctl
    task automatic send(input logic [7:0] d);
        repeat (700) if (!tx_buffer_empty) @(negedge clk_sys);
        data_wdata = {8'h00, d};
        pulse(data_wr);
    endtask : send
    task automatic wait_rx();
        repeat (700) if (!rx_buffer_full) @(negedge clk_sys);
    endtask : wait_rx
    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? checksum_polynomial[7:0] : 8'h00);
        return c;
    endfunction : crc8
    initial begin
        {ctl_a_wr, cfg_enable, cfg_master, cfg_send_checksum_next, single_wire_drive_out} = '0;
        {error_irq_enable, tx_irq_enable, rx_irq_enable, tx_dma_enable, rx_dma_enable} = '0;
        {data_wr, data_rd, status_access, status_rd, status_crc_clr, tx_dma_ack} = '0;
        {tx_dma_last, rx_dma_ack, slave_select_n} = 3'b001;
        {cfg_bits, data_wdata, checksum_polynomial} = {8'h00, 16'h0000, 16'h0007};
        // A real falling edge resets the link side, whose first clock edge, at 53 ns, comes after reset is released at 16 ns.
        #1;
        arst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("txe_off", 1'b0, tx_buffer_empty)
        ctl(1'b1, 1'b1, 1'b0, 8'h0c);
        rx_dma_enable = 1'b1;
        repeat (100) @(negedge clk_sys);
        `CHK("txe_on", 1'b1, tx_buffer_empty)
        send(8'ha5);
        `CHK("busy", 2'b10, {busy_flag, tx_buffer_empty})
        wait_rx();
        `CHK("rx_data", 8'h3c, data_rdata[7:0])
        @(negedge clk_sys);
        `CHK("rx_dma", 1'b1, rx_dma_req)
        pulse(data_rd);
        `CHK("rx_clear", 1'b0, rx_buffer_full)
        send(8'h11);
        send(8'h22);
        repeat (700) if (!overrun_flag) @(negedge clk_sys);
        `CHK("ovr_keep", 9'h1c3, {overrun_flag, data_rdata[7:0]})
        pulse(data_rd);
        `CHK("ovr_hold", 1'b1, overrun_flag)
        pulse(status_rd);
        `CHK("ovr_clear", 1'b0, overrun_flag)
        ctl(1'b1, 1'b1, 1'b0, 8'h8c);
        repeat (100) @(negedge clk_sys);
        send(8'h5a);
        ctl(1'b1, 1'b1, 1'b1, 8'h8c);
        wait_rx();
        `CHK("tx_sum", crc8(8'h5a), tx_checksum_value[7:0])
        `CHK("rx_sum", crc8(8'hc3), rx_checksum_value[7:0])
        pulse(data_rd);
        repeat (700) if (send_checksum_next) @(negedge clk_sys);
        repeat (10) @(negedge clk_sys);
        `CHK("sum_err", 3'b010, {send_checksum_next, checksum_mismatch_flag, rx_buffer_full})
        error_irq_enable = 1'b1;
        ctl(1'b1, 1'b1, 1'b0, 8'h04);
        repeat (4) @(negedge clk_sys);
        `CHK("fault", 4'b1001, {mode_fault_flag, periph_enable, master_select, irq})
        ctl(1'b1, 1'b1, 1'b0, 8'h0c);
        `CHK("fault_lock", 3'b100, {mode_fault_flag, periph_enable, master_select})
        pulse(status_access);
        ctl(1'b1, 1'b1, 1'b0, 8'h0c);
        `CHK("fault_clr", 1'b0, mode_fault_flag)
        ctl(1'b1, 1'b0, 1'b0, 8'h06);
        repeat (200) @(negedge clk_sys);
        `CHK("rxo_pins", 3'b000, {mosi_oe, miso_oe, mode_fault_flag})
        complete_run();
    end
endmodule : spx_ctrl_test
